/* File: design/wiper_advanced_control.sv */
// Wiper setting register control for a two-channel digital potentiometer.
//
// Function
// RQ1: Top or bottom scale keeps the wiper setting.
// RQ2: Leave scale positions on exit, load, shutdown.
// RQ3: Top scale selects the documented path resistances.
// RQ4: Bottom scale selects the documented path resistances.
// RQ5: Linear increment and decrement move one position.
// RQ6: Steps apply to one or all channels.
// RQ7: Commands raise or lower by one 6 dB.
// RQ8: Left shift doubles, zero to one, saturate.
// RQ9: Right shift halves with zero fill.
// RQ10: Reset by software command or reset pin.
// RQ11: Reset reloads wipers from nonvolatile copy.
// RQ12: Power-up loads wipers from nonvolatile memory.
// RQ13: Shutdown command with bit one enters shutdown.
// RQ14: Shutdown command with bit zero exits shutdown.
// RQ15: Shutdown leaves the wiper setting unchanged.
// RQ16: Commands still execute while in shutdown.
// RQ17: Shutdown opens paths per string select bit; the code follows the bit in linear mode only.
// RQ18: Two control bits protect wiper and memory.
// RQ19: Protected wipers accept only nonvolatile copy.
// RQ20: Linear gain when pin or control bit set.
// RQ21: Linear steps saturate at the ends.
// RQ22: Width parameter covers the 128-position variant.
`timescale 1ns/1ps
`default_nettype none
module wiper_advanced_control #(
   parameter int WIDTH         = 8,
   parameter int RELOAD_CYCLES = wiper_pkg::RELOAD_CYCLES
) (
   // Clock, reset and enable.
   input  wire logic                   mclk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   clk_en_i,
   // Pins from outside the clock domain.
   input  wire logic                   reset_pin_n_i,
   input  wire logic                   independent_mode_pin_i,
   // Decoded command from the serial decoder.
   input  wire wiper_pkg::cmd_type     cmd_i,
   // Nonvolatile copies, one per channel.
   input  wire logic [2*WIDTH-1:0]     nv_value_i,
   // Register port.
   input  wire logic [1:0]             addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic [7:0]                  rdata_o,
   // Wiper state, switches, memory write port and busy flag.
   output logic [2*WIDTH-1:0]          wiper_setting_register_o,
   output wiper_pkg::switch_type [1:0] switch_o,
   output logic                        nv_write_o,
   output logic [WIDTH-1:0]            nv_wdata_o,
   output logic                        nv_chan_o,
   output logic                        busy_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   localparam logic [WIDTH-1:0] FULL = {WIDTH{1'b1}};  // Full scale, see RQ22.
   localparam logic [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};
   localparam logic [1:0] ADDR_CTRL  = 2'h0;
   localparam logic [1:0] ADDR_WIPE0 = 2'h1;
   localparam logic [1:0] ADDR_WIPE1 = 2'h2;
   localparam logic [1:0] ADDR_STAT  = 2'h3;

   // Whole module state as one packed struct.
   typedef struct packed {
      logic [1:0][WIDTH-1:0] wiper;   // Wiper setting registers.
      logic [1:0]            top;     // Top scale active.
      logic [1:0]            bot;     // Bottom scale active.
      logic [1:0]            sd;      // Shutdown active.
      logic [1:0]            sd_str;  // String select latched with shutdown.
      logic [3:0]            ctrl;    // Control register.
      wiper_pkg::seq_type    seq;     // Reload sequencer.
      logic [15:0]           cnt;     // Reload timer.
      logic [1:0]            rp_sync; // Reset pin synchroniser.
      logic [1:0]            ip_sync; // Mode pin synchroniser.
      logic [7:0]            rdata;   // Read data.
      logic                  nv_wr;   // Memory write strobe.
      logic [WIDTH-1:0]      nv_dat;  // Memory write data.
      logic                  nv_ch;   // Memory write channel.
   } state_type;

   state_type s_q;
   state_type s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers.

   // Doubles a setting; zero goes to one and overflow saturates.
   function automatic logic [WIDTH-1:0] up6(input logic [WIDTH-1:0] v);
      if (v == '0) begin
         up6 = ONE;                                  // see RQ8
      end else if (v[WIDTH-1]) begin
         up6 = FULL;                                 // see RQ8
      end else begin
         up6 = {v[WIDTH-2:0], 1'b0};                 // see RQ8
      end
   endfunction

   // Halves a setting with zero fill.
   function automatic logic [WIDTH-1:0] down6(input logic [WIDTH-1:0] v);
      down6 = {1'b0, v[WIDTH-1:1]};                  // see RQ9
   endfunction

   // Tells whether a command addresses a channel.
   function automatic logic hits(input wiper_pkg::cmd_type c, input int ch);
      hits = c.all_ch || (c.chan == ch[0]);          // see RQ6
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next state. The reload window blocks new commands so a reset is not torn.

   logic rp_low;
   logic linear;
   logic reload_start;

   assign rp_low = ~s_q.rp_sync[1];
   assign linear = s_q.ip_sync[1] | s_q.ctrl[wiper_pkg::CTRL_LINEAR_BIT];  // see RQ20

   always_comb begin
      s_d          = s_q;
      reload_start = 1'b0;
      s_d.nv_wr    = 1'b0;
      s_d.rp_sync  = {s_q.rp_sync[0], reset_pin_n_i};
      s_d.ip_sync  = {s_q.ip_sync[0], independent_mode_pin_i};
      s_d.rdata    = 8'h00;
      // Register port reads.
      if (rd_i) begin
         case (addr_i)
            ADDR_CTRL:  s_d.rdata = {4'h0, s_q.ctrl};
            ADDR_WIPE0: s_d.rdata = 8'(s_q.wiper[0]);
            ADDR_WIPE1: s_d.rdata = 8'(s_q.wiper[1]);
            ADDR_STAT:  s_d.rdata = {1'b0, s_q.seq == wiper_pkg::ST_RELOAD, s_q.sd,
                                     s_q.bot, s_q.top};
            default:    s_d.rdata = 8'h00;
         endcase
      end
      // Register port write of the control register.
      if (wr_i && addr_i == ADDR_CTRL) begin
         s_d.ctrl = wdata_i[3:0];                    // see RQ18
      end
      if (rp_low) begin
         reload_start = 1'b1;                        // see RQ10
      end
      if (cmd_i.valid && s_q.seq != wiper_pkg::ST_RELOAD) begin
         // Commands run regardless of shutdown.
         for (int ch = 0; ch < 2; ch++) begin        // see RQ16
            if (hits(cmd_i, ch)) begin
               logic load;
               logic [WIDTH-1:0] nv;
               load = 1'b0;
               nv   = nv_value_i[ch*WIDTH +: WIDTH];
               case (cmd_i.op)
                  wiper_pkg::OP_WRITE: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_WIPER_PROT_BIT]) begin  // see RQ19
                        s_d.wiper[ch] = cmd_i.data[WIDTH-1:0];
                        load = 1'b1;
                     end
                  end
                  wiper_pkg::OP_INC: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_WIPER_PROT_BIT]) begin  // see RQ19
                        if (s_q.wiper[ch] != FULL) begin                   // see RQ21
                           s_d.wiper[ch] = s_q.wiper[ch] + ONE;            // see RQ5
                        end
                        load = 1'b1;
                     end
                  end
                  wiper_pkg::OP_DEC: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_WIPER_PROT_BIT]) begin  // see RQ19
                        if (s_q.wiper[ch] != '0) begin                     // see RQ21
                           s_d.wiper[ch] = s_q.wiper[ch] - ONE;            // see RQ5
                        end
                        load = 1'b1;
                     end
                  end
                  wiper_pkg::OP_UP6DB: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_WIPER_PROT_BIT]) begin  // see RQ19
                        s_d.wiper[ch] = up6(s_q.wiper[ch]);                // see RQ7
                        load = 1'b1;
                     end
                  end
                  wiper_pkg::OP_DOWN6DB: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_WIPER_PROT_BIT]) begin  // see RQ19
                        s_d.wiper[ch] = down6(s_q.wiper[ch]);              // see RQ7
                        load = 1'b1;
                     end
                  end
                  wiper_pkg::OP_NV_LOAD: begin
                     s_d.wiper[ch] = nv;                                   // see RQ19
                     load = 1'b1;
                  end
                  wiper_pkg::OP_NV_STORE: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_NV_PROT_BIT]) begin     // see RQ18
                        s_d.nv_wr  = 1'b1;
                        s_d.nv_dat = s_q.wiper[ch];
                        s_d.nv_ch  = ch[0];
                     end
                  end
                  wiper_pkg::OP_NV_WRITE: begin
                     if (!s_q.ctrl[wiper_pkg::CTRL_NV_PROT_BIT]) begin     // see RQ18
                        s_d.nv_wr  = 1'b1;
                        s_d.nv_dat = cmd_i.data[WIDTH-1:0];
                        s_d.nv_ch  = ch[0];
                     end
                  end
                  wiper_pkg::OP_TOP: begin
                     // Only the switches change, see RQ1.
                     s_d.top[ch] = cmd_i.data[0];
                     if (cmd_i.data[0]) begin
                        s_d.bot[ch] = 1'b0;
                     end
                  end
                  wiper_pkg::OP_BOTTOM: begin
                     s_d.bot[ch] = cmd_i.data[0];    // see RQ1
                     if (cmd_i.data[0]) begin
                        s_d.top[ch] = 1'b0;
                     end
                  end
                  wiper_pkg::OP_SHUTDOWN: begin
                     s_d.sd[ch]     = cmd_i.data[0]; // see RQ13, RQ14
                     s_d.sd_str[ch] = cmd_i.string_sel;
                     s_d.top[ch]    = 1'b0;          // see RQ2
                     s_d.bot[ch]    = 1'b0;          // see RQ2
                  end
                  default: begin
                  end
               endcase
               if (load) begin
                  s_d.top[ch] = 1'b0;                // see RQ2
                  s_d.bot[ch] = 1'b0;                // see RQ2
               end
            end
         end
         if (cmd_i.op == wiper_pkg::OP_SWRESET) begin
            reload_start = 1'b1;                     // see RQ10
         end
      end
      // Reload sequencer: reload at start, hold busy for the reload time.
      case (s_q.seq)
         wiper_pkg::ST_IDLE, wiper_pkg::ST_DONE: begin
            if (reload_start) begin
               s_d.seq = wiper_pkg::ST_RELOAD;
               s_d.cnt = 16'(RELOAD_CYCLES - 1);
               for (int ch = 0; ch < 2; ch++) begin
                  s_d.wiper[ch] = nv_value_i[ch*WIDTH +: WIDTH];  // see RQ11
                  s_d.top[ch]   = 1'b0;
                  s_d.bot[ch]   = 1'b0;
                  s_d.sd[ch]    = 1'b0;
               end
            end
         end
         wiper_pkg::ST_RELOAD: begin
            if (s_q.cnt == 16'h0000) begin
               s_d.seq = wiper_pkg::ST_DONE;
            end else begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
         default: s_d.seq = wiper_pkg::ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register stage. Reset enters the reload state so power-up loads from memory.

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s_q         <= '0;
         s_q.seq     <= wiper_pkg::ST_RELOAD;        // see RQ12
         s_q.cnt     <= 16'(RELOAD_CYCLES - 1);
         s_q.rp_sync <= 2'b11;
      end else if (clk_en_i) begin
         s_q <= s_d;
         if (s_q.seq == wiper_pkg::ST_RELOAD && s_q.cnt == 16'(RELOAD_CYCLES - 1)) begin
            s_q.wiper <= nv_value_i;                 // see RQ12
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Switch decode. Scale and shutdown only override selection, never the setting.

   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         switch_o[ch] = '{wiper_pkg::PATH_WIPER, 1'b0, wiper_pkg::PATH_WIPER, 1'b0};
         if (s_q.sd[ch]) begin                       // see RQ17
            if (linear) begin
               if (s_q.sd_str[ch]) begin
                  switch_o[ch].aw_open = 1'b1;
               end else begin
                  switch_o[ch].wb_open = 1'b1;
               end
            end else begin
               switch_o[ch].aw_open = 1'b1;
               switch_o[ch].wb_sel  = wiper_pkg::PATH_BOTTOM;
            end
         end else if (s_q.top[ch]) begin             // see RQ3
            switch_o[ch].aw_sel = linear ? wiper_pkg::PATH_FULL : wiper_pkg::PATH_TOP;
            switch_o[ch].wb_sel = wiper_pkg::PATH_FULL;
         end else if (s_q.bot[ch]) begin             // see RQ4
            switch_o[ch].aw_sel = linear ? wiper_pkg::PATH_TOP : wiper_pkg::PATH_FULL;
            switch_o[ch].wb_sel = wiper_pkg::PATH_BOTTOM;
         end
      end
   end

   assign wiper_setting_register_o = s_q.wiper;
   assign rdata_o    = s_q.rdata;
   assign nv_write_o = s_q.nv_wr;
   assign nv_wdata_o = s_q.nv_dat;
   assign nv_chan_o  = s_q.nv_ch;
   assign busy_o     = (s_q.seq == wiper_pkg::ST_RELOAD);

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence top_cmd_s;
      cmd_i.valid && cmd_i.op == wiper_pkg::OP_TOP && !busy_o && clk_en_i && !rp_low;
   endsequence

   scale_keeps_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ1
      top_cmd_s |=> $stable(wiper_setting_register_o))
      else $error("Scale entry changed the wiper.");
   shutdown_exit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ2
      (cmd_i.valid && cmd_i.op == wiper_pkg::OP_SHUTDOWN && !busy_o && clk_en_i)
      |=> !s_q.top[$past(cmd_i.chan)] && (s_q.top == 2'b00 || !$past(cmd_i.all_ch)))
      else $error("Shutdown did not leave scale.");
   top_paths_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ3
      (s_q.top[0] && !s_q.sd[0] && !linear) |-> switch_o[0].aw_sel == wiper_pkg::PATH_TOP)
      else $error("Top scale path wrong.");
   bot_paths_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ4
      (s_q.bot[0] && !s_q.top[0] && !s_q.sd[0])
      |-> switch_o[0].wb_sel == wiper_pkg::PATH_BOTTOM)
      else $error("Bottom scale path wrong.");
   sd_keeps_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ15
      (cmd_i.valid && cmd_i.op == wiper_pkg::OP_SHUTDOWN && !busy_o && clk_en_i && !rp_low)
      |=> $stable(wiper_setting_register_o))
      else $error("Shutdown changed the wiper.");
   prot_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ19
      (s_q.ctrl[wiper_pkg::CTRL_WIPER_PROT_BIT] && cmd_i.valid && !busy_o && clk_en_i
       && cmd_i.op == wiper_pkg::OP_WRITE && !rp_low) |=> $stable(wiper_setting_register_o))
      else $error("Protected wiper was written.");
   nv_prot_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ18
      s_q.ctrl[wiper_pkg::CTRL_NV_PROT_BIT] && $past(s_q.ctrl[wiper_pkg::CTRL_NV_PROT_BIT])
      |-> !nv_write_o)
      else $error("Protected memory was written.");
   reload_busy_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // see RQ11
      $rose(busy_o) |-> wiper_setting_register_o == $past(nv_value_i) || !$past(rst_n_i))
      else $error("Reset did not reload the wiper.");

endmodule
`default_nettype wire

/* File: design/wiper_pkg.sv */
// Package with constants and carrier types for the wiper control block.
package wiper_pkg;
   // Operation codes presented by the command decoder.
   localparam logic [3:0] OP_NOP       = 4'h0;
   localparam logic [3:0] OP_WRITE     = 4'h1;
   localparam logic [3:0] OP_INC       = 4'h4;
   localparam logic [3:0] OP_DEC       = 4'h5;
   localparam logic [3:0] OP_UP6DB     = 4'h6;
   localparam logic [3:0] OP_DOWN6DB   = 4'h7;
   localparam logic [3:0] OP_COPY_IN   = 4'h8;
   localparam logic [3:0] OP_NV_STORE  = 4'h9;
   localparam logic [3:0] OP_NV_LOAD   = 4'hA;
   localparam logic [3:0] OP_NV_WRITE  = 4'hB;
   localparam logic [3:0] OP_TOP       = 4'hC;
   localparam logic [3:0] OP_BOTTOM    = 4'hD;
   localparam logic [3:0] OP_SWRESET   = 4'hE;
   localparam logic [3:0] OP_SHUTDOWN  = 4'hF;
   localparam logic [3:0] OP_CTRL      = 4'h3;
   // Control register field positions.
   localparam int CTRL_WIPER_PROT_BIT = 1;
   localparam int CTRL_NV_PROT_BIT    = 0;
   localparam int CTRL_LINEAR_BIT     = 2;
   localparam logic [3:0] CTRL_RESET  = 4'h0;
   // Reset reload timing.
   localparam int RELOAD_TIME_NS = 30000;
   localparam int CLK_PERIOD_NS  = 25;
   localparam int RELOAD_CYCLES  = RELOAD_TIME_NS / CLK_PERIOD_NS;
   // Path selection codes for each resistor string.
   typedef enum logic [1:0] {
      PATH_WIPER  = 2'h0,
      PATH_FULL   = 2'h1,
      PATH_TOP    = 2'h2,
      PATH_BOTTOM = 2'h3
   } path_sel_type;
   // Decoded command from the serial decoder.
   typedef struct packed {
      logic       valid;
      logic [3:0] op;
      logic       all_ch;
      logic       string_sel;
      logic       chan;
      logic [7:0] data;
   } cmd_type;
   // Switch state for one channel.
   typedef struct packed {
      path_sel_type aw_sel;
      logic         aw_open;
      path_sel_type wb_sel;
      logic         wb_open;
   } switch_type;
   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_RELOAD = 2'b01,
      ST_DONE   = 2'b11
   } seq_type;
endpackage

/* File: bench/cmd_decoder_model.sv */
// Behavioural model of the serial command decoder that feeds the wiper block.
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_model (
   // Clock.
   input  wire logic              mclk_i,
   // Decoded command towards the block.
   output var wiper_pkg::cmd_type cmd_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Issues one command for one cycle, then shows its inverse as idle.
   task automatic send(input logic [3:0] op, input logic all_ch, input logic chan,
                       input logic sel, input logic [7:0] data);
      wiper_pkg::cmd_type c;
      c = {1'b1, op, all_ch, sel, chan, data};
      @(posedge mclk_i);
      cmd_o <= c;
      @(posedge mclk_i);
      cmd_o <= {1'b0, ~c[14:0]};
   endtask

   // The idle pattern is not zero on purpose.
   initial begin
      cmd_o = {1'b0, 15'h2A5A};
   end
endmodule
`default_nettype wire

/* File: bench/wiper_advanced_control_tb.sv */
// Self-checking testbench for the wiper control block.
`timescale 1ns/1ps
`default_nettype none
module wiper_advanced_control_tb;
   // Table row: operation, start and expected values.
   typedef struct packed {
      logic [3:0] op;
      logic [7:0] start;
      logic [7:0] exp;
   } row_type;
   localparam int RC = 4;                 // Short reload keeps the run brief.
   logic                        mclk_i = 1'b0;
   logic                        rst_n_i;
   logic                        clk_en_i;
   logic                        reset_pin_n_i;
   logic                        independent_mode_pin_i;
   wiper_pkg::cmd_type          cmd;
   logic [15:0]                 nv_value_i;
   logic [1:0]                  addr_i;
   logic [7:0]                  wdata_i;
   logic                        wr_i;
   logic                        rd_i;
   logic [7:0]                  rdata_o;
   logic [15:0]                 wiper_o;
   wiper_pkg::switch_type [1:0] sw_o;
   logic                        nv_write_o;
   logic [7:0]                  nv_wdata_o;
   logic                        nv_chan_o;
   logic                        busy_o;
   int                          failures = 0;
   int                          checks = 0;
   int                          nvw = 0;   // Count of store pulses seen.
   int                          n;
   int                          p;
   row_type rows [13] = '{
      '{wiper_pkg::OP_INC, 8'h05, 8'h06},
      '{wiper_pkg::OP_INC, 8'hFF, 8'hFF},
      '{wiper_pkg::OP_DEC, 8'h05, 8'h04},
      '{wiper_pkg::OP_DEC, 8'h00, 8'h00},
      '{wiper_pkg::OP_UP6DB, 8'h00, 8'h01},
      '{wiper_pkg::OP_UP6DB, 8'h01, 8'h02},
      '{wiper_pkg::OP_UP6DB, 8'h40, 8'h80},
      '{wiper_pkg::OP_UP6DB, 8'h80, 8'hFF},
      '{wiper_pkg::OP_UP6DB, 8'hC3, 8'hFF},
      '{wiper_pkg::OP_DOWN6DB, 8'hFF, 8'h7F},
      '{wiper_pkg::OP_DOWN6DB, 8'h00, 8'h00},
      '{wiper_pkg::OP_DOWN6DB, 8'h81, 8'h40},
      '{wiper_pkg::OP_DOWN6DB, 8'h01, 8'h00}
   };

   ////////////////////////////////////////////////////////////////////////////
   // Clock, partner and device.
   always #12.5 mclk_i = ~mclk_i;
   cmd_decoder_model dec (.mclk_i(mclk_i), .cmd_o(cmd));
   wiper_advanced_control #(.WIDTH(8), .RELOAD_CYCLES(RC)) DUT (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .reset_pin_n_i(reset_pin_n_i), .independent_mode_pin_i(independent_mode_pin_i),
      .cmd_i(cmd), .nv_value_i(nv_value_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wiper_setting_register_o(wiper_o),
      .switch_o(sw_o), .nv_write_o(nv_write_o), .nv_wdata_o(nv_wdata_o),
      .nv_chan_o(nv_chan_o), .busy_o(busy_o));

   // The store pulse lasts one cycle, so it is counted on every edge.
   always @(posedge mclk_i) if (nv_write_o === 1'b1) nvw++;

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, bus and command helpers.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_sw(input logic [1:0] a, input logic ao, input logic [1:0] b,
                         input logic bo);
      chk({10'h0, sw_o[0]}, {10'h0, a, ao, b, bo});
   endtask
   task automatic cmd_go(input logic [3:0] op, input logic all_ch, input logic chan,
                         input logic sel, input logic [7:0] data);
      dec.send(op, all_ch, chan, sel, data);
      #1;
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
      @(posedge mclk_i);
      {wr_i, addr_i, wdata_i} <= {1'b0, ~a, ~d};
      #1;
   endtask
   task automatic reg_rd(input logic [1:0] a);
      @(posedge mclk_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge mclk_i);
      {rd_i, addr_i} <= {1'b0, ~a};
      #1;
   endtask
   // Waits a bounded time for the reload; n counts edges.
   task automatic wait_idle();
      n = 0;
      while (busy_o !== 1'b0 && n < 100) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk({15'h0, busy_o}, 16'h0);
   endtask
   task automatic test_done();
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: the run needs well under a thousand cycles.
   initial begin
      #200us;
      failures++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {rst_n_i, wr_i, rd_i, independent_mode_pin_i} = 4'h0;
      clk_en_i = 1'b1;
      reset_pin_n_i = 1'b1;
      nv_value_i = 16'h8080;
      {addr_i, wdata_i} = 10'h0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      wait_idle();
      chk(16'(n + 1), 16'(RC));
      chk(wiper_o, 16'h8080);
      // Table of single-channel steps, each read back over the port.
      foreach (rows[i]) begin
         cmd_go(wiper_pkg::OP_WRITE, 1'b0, 1'b0, 1'b0, rows[i].start);
         cmd_go(rows[i].op, 1'b0, 1'b0, 1'b0, 8'h01);
         chk(wiper_o, {8'h80, rows[i].exp});
         reg_rd(2'h1);
         chk({8'h0, rdata_o}, {8'h0, rows[i].exp});
      end
      // Ganged steps move both channels at once.
      cmd_go(wiper_pkg::OP_WRITE, 1'b0, 1'b1, 1'b0, 8'h10);
      cmd_go(wiper_pkg::OP_WRITE, 1'b0, 1'b0, 1'b0, 8'h20);
      cmd_go(wiper_pkg::OP_INC, 1'b1, 1'b0, 1'b0, 8'h01);
      chk(wiper_o, 16'h1121);
      cmd_go(wiper_pkg::OP_UP6DB, 1'b1, 1'b0, 1'b0, 8'h01);
      chk(wiper_o, 16'h2242);
      cmd_go(wiper_pkg::OP_DEC, 1'b1, 1'b0, 1'b0, 8'h00);
      chk(wiper_o, 16'h2141);
      // Top scale in both modes, then left by an increment.
      cmd_go(wiper_pkg::OP_TOP, 1'b0, 1'b0, 1'b0, 8'h81);
      chk(wiper_o, 16'h2141);
      chk_sw(wiper_pkg::PATH_TOP, 1'b0, wiper_pkg::PATH_FULL, 1'b0);
      reg_rd(2'h3);
      chk({8'h0, rdata_o}, 16'h0001);
      reg_wr(2'h0, 8'h04);
      chk_sw(wiper_pkg::PATH_FULL, 1'b0, wiper_pkg::PATH_FULL, 1'b0);
      cmd_go(wiper_pkg::OP_INC, 1'b0, 1'b0, 1'b0, 8'h01);
      chk_sw(wiper_pkg::PATH_WIPER, 1'b0, wiper_pkg::PATH_WIPER, 1'b0);
      chk(wiper_o, 16'h2142);
      // Bottom scale in both modes, left by the explicit exit.
      cmd_go(wiper_pkg::OP_BOTTOM, 1'b0, 1'b0, 1'b0, 8'h01);
      chk_sw(wiper_pkg::PATH_TOP, 1'b0, wiper_pkg::PATH_BOTTOM, 1'b0);
      reg_wr(2'h0, 8'h00);
      chk_sw(wiper_pkg::PATH_FULL, 1'b0, wiper_pkg::PATH_BOTTOM, 1'b0);
      cmd_go(wiper_pkg::OP_BOTTOM, 1'b0, 1'b0, 1'b0, 8'h00);
      chk_sw(wiper_pkg::PATH_WIPER, 1'b0, wiper_pkg::PATH_WIPER, 1'b0);
      // The mode pin alone selects linear gain; it passes a synchroniser.
      @(posedge mclk_i) independent_mode_pin_i <= 1'b1;
      cmd_go(wiper_pkg::OP_TOP, 1'b0, 1'b0, 1'b0, 8'h81);
      repeat (3) @(posedge mclk_i);
      #1;
      chk_sw(wiper_pkg::PATH_FULL, 1'b0, wiper_pkg::PATH_FULL, 1'b0);
      @(posedge mclk_i) independent_mode_pin_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1;
      // Shutdown leaves top scale; commands still run meanwhile.
      cmd_go(wiper_pkg::OP_SHUTDOWN, 1'b0, 1'b0, 1'b0, 8'h01);
      chk({14'h0, sw_o[0].aw_open, sw_o[0].wb_sel == wiper_pkg::PATH_BOTTOM}, 16'h3);
      cmd_go(wiper_pkg::OP_INC, 1'b0, 1'b0, 1'b0, 8'h01);
      chk(wiper_o, 16'h2143);
      reg_wr(2'h0, 8'h04);
      chk({15'h0, sw_o[0].wb_open}, 16'h1);
      cmd_go(wiper_pkg::OP_SHUTDOWN, 1'b0, 1'b0, 1'b1, 8'h01);
      chk({15'h0, sw_o[0].aw_open}, 16'h1);
      reg_wr(2'h0, 8'h00);
      cmd_go(wiper_pkg::OP_SHUTDOWN, 1'b0, 1'b0, 1'b0, 8'h00);
      @(posedge mclk_i) clk_en_i <= 1'b0;
      cmd_go(wiper_pkg::OP_INC, 1'b0, 1'b0, 1'b0, 8'h01);
      @(posedge mclk_i) clk_en_i <= 1'b1;
      chk_sw(wiper_pkg::PATH_WIPER, 1'b0, wiper_pkg::PATH_WIPER, 1'b0);
      chk(wiper_o, 16'h2143);
      // Wiper protection lets only the nonvolatile copy through.
      reg_wr(2'h0, 8'h02);
      reg_rd(2'h0);
      chk({8'h0, rdata_o}, 16'h0002);
      cmd_go(wiper_pkg::OP_WRITE, 1'b0, 1'b0, 1'b0, 8'h55);
      cmd_go(wiper_pkg::OP_INC, 1'b0, 1'b0, 1'b0, 8'h01);
      chk(wiper_o, 16'h2143);
      cmd_go(wiper_pkg::OP_NV_LOAD, 1'b0, 1'b0, 1'b0, 8'h00);
      chk(wiper_o, 16'h2180);
      // Memory protection suppresses the store pulse.
      reg_wr(2'h0, 8'h01);
      p = nvw;
      cmd_go(wiper_pkg::OP_NV_STORE, 1'b0, 1'b0, 1'b0, 8'h01);
      repeat (2) @(posedge mclk_i);
      chk(16'(nvw - p), 16'h0);
      reg_wr(2'h0, 8'h00);
      cmd_go(wiper_pkg::OP_NV_STORE, 1'b0, 1'b0, 1'b0, 8'h01);
      repeat (2) @(posedge mclk_i);
      chk(16'(nvw - p), 16'h1);
      cmd_go(wiper_pkg::OP_NV_WRITE, 1'b0, 1'b1, 1'b0, 8'h5A);
      chk({nv_chan_o, 7'h0, nv_wdata_o}, 16'h805A);
      // Software reset reloads; a command while busy is refused.
      @(posedge mclk_i) nv_value_i <= 16'h3C5A;
      cmd_go(wiper_pkg::OP_SWRESET, 1'b0, 1'b0, 1'b0, 8'h00);
      cmd_go(wiper_pkg::OP_INC, 1'b1, 1'b0, 1'b0, 8'h01);
      wait_idle();
      chk(wiper_o, 16'h3C5A);
      // Reset pin pulse reloads from a new copy.
      @(posedge mclk_i) nv_value_i <= 16'h1234;
      reset_pin_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      reset_pin_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1;
      wait_idle();
      chk(wiper_o, 16'h1234);
      // A second system reset in mid-run.
      @(posedge mclk_i) nv_value_i <= 16'h8080;
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      wait_idle();
      chk(wiper_o, 16'h8080);
      test_done();
   end
endmodule
`default_nettype wire
